// File: design/mod_map.vh
`ifndef MOD_MAP_VH
`define MOD_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MOD_OFF_CTRL 8'h00
`define MOD_OFF_CMD 8'h04
`define MOD_OFF_STREAM 8'h08
`define MOD_OFF_GPR_AC 8'h10
`define MOD_OFF_GPR_DB 8'h14
`define MOD_OFF_GPR_SF 8'h18
`define MOD_OFF_GPR_SD 8'h1C
`define MOD_OFF_SEG_EC 8'h20
`define MOD_OFF_SEG_SD 8'h24
`define MOD_OFF_EFF_ADDR 8'h28
`define MOD_OFF_PHYS 8'h2C
`define MOD_OFF_OPER 8'h30
`define MOD_OFF_STATUS 8'h34

// ----------------------------------------
// control fields
// ----------------------------------------
`define MOD_CTRL_WORD 8
`define MOD_CTRL_OVR_LO 9
`define MOD_CTRL_OVR_HI 10
`define MOD_CTRL_OVR_EN 11
`define MOD_CTRL_STRDST 12
`define MOD_CTRL_WIDE 13
`define MOD_CTRL_RST 32'h0000_0000
`define MOD_CMD_START 0

// ----------------------------------------
// encodings and timing
// ----------------------------------------
`define MOD_MODE_NODISP 2'h0
`define MOD_MODE_DISP8 2'h1
`define MOD_MODE_DISP16 2'h2
`define MOD_MODE_REG 2'h3
`define MOD_RM_DIRECT 3'h6
`define MOD_SEG_EXTRA 2'h0
`define MOD_SEG_CODE 2'h1
`define MOD_SEG_STACK 2'h2
`define MOD_SEG_DATA 2'h3
`define MOD_ADDR_CYCLES 8'h04
`define MOD_WORD_XFER_CYCLES 8'h04
`define MOD_RESP_OKAY 2'h0
`define MOD_RESP_SLVERR 2'h2

`endif

// File: design/mod_decode.v
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "mod_map.vh"

module mod_decode (
  input wire mclk,
  input wire nrst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ----------------------------------------
  // state codes and functions
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_CALC = 3'h2;
  localparam [2:0] ST_FINISH = 3'h4;
  function [31:0] merge_strb;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      merge_strb = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          merge_strb[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
  endfunction
  // register operand by 3-bit code, word or byte width
  function [15:0] reg_pick;
    input [2:0] code;
    input word;
    input [127:0] regs;
    reg [15:0] r;
    begin
      r = 16'h0000;
      if (word) begin
        reg_pick = regs[code*16 +: 16];
      end else begin
        r = regs[{1'b0, code[1:0]}*16 +: 16];
        reg_pick = {8'h00, code[2] ? r[15:8] : r[7:0]};
      end
    end
  endfunction
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [31:0] ctrl_reg;
  reg [31:0] stream_reg;
  reg [31:0] gpr_ac_reg;
  reg [31:0] gpr_db_reg;
  reg [31:0] gpr_sf_reg;
  reg [31:0] gpr_sd_reg;
  reg [31:0] seg_ec_reg;
  reg [31:0] seg_sd_reg;
  reg [2:0] state_reg;
  reg [7:0] cnt_reg;
  reg done_reg;
  reg [15:0] eff_addr_reg;
  reg [19:0] phys_reg;
  reg [15:0] oper_reg;
  reg [15:0] regfld_reg;
  reg mem_reg;
  reg [1:0] seg_sel_reg;
  reg [1:0] disp_len_reg;
  reg [7:0] cost_reg;

  // ----------------------------------------
  // named operands and field decode
  // ----------------------------------------
  wire [15:0] accumulator_reg = gpr_ac_reg[15:0];
  wire [15:0] count_reg = gpr_ac_reg[31:16];
  wire [15:0] data_word_reg = gpr_db_reg[15:0];
  wire [15:0] base_word_reg = gpr_db_reg[31:16];
  wire [15:0] stack_pointer_reg = gpr_sf_reg[15:0];
  wire [15:0] frame_base_reg = gpr_sf_reg[31:16];
  wire [15:0] source_index_reg = gpr_sd_reg[15:0];
  wire [15:0] dest_index_reg = gpr_sd_reg[31:16];
  wire [15:0] extra_segment = seg_ec_reg[15:0];
  wire [15:0] code_segment = seg_ec_reg[31:16];
  wire [15:0] stack_segment = seg_sd_reg[15:0];
  wire [15:0] data_segment = seg_sd_reg[31:16];
  wire [127:0] reg_bank = {dest_index_reg, source_index_reg, frame_base_reg,
    stack_pointer_reg, base_word_reg, data_word_reg, count_reg, accumulator_reg};
  wire [1:0] mode_f = ctrl_reg[7:6];
  wire [2:0] reg_f = ctrl_reg[5:3];
  wire [2:0] rm_f = ctrl_reg[2:0];
  wire word_f = ctrl_reg[`MOD_CTRL_WORD];
  wire [1:0] ovr_f = ctrl_reg[`MOD_CTRL_OVR_HI:`MOD_CTRL_OVR_LO];
  wire ovr_en = ctrl_reg[`MOD_CTRL_OVR_EN];
  wire str_dst = ctrl_reg[`MOD_CTRL_STRDST];
  wire wide_f = ctrl_reg[`MOD_CTRL_WIDE];
  wire is_direct = (mode_f == `MOD_MODE_NODISP) && (rm_f == `MOD_RM_DIRECT);
  // displacement bytes sit first in the stream, ahead of immediates
  wire [7:0] disp_lo = stream_reg[7:0];
  wire [7:0] disp_hi = stream_reg[15:8];
  reg [15:0] disp_c;
  reg [1:0] disp_len_c;
  always @* begin
    case (mode_f)
      `MOD_MODE_NODISP: begin
        disp_c = is_direct ? {disp_hi, disp_lo} : 16'h0000;
        disp_len_c = is_direct ? 2'd2 : 2'd0;
      end
      `MOD_MODE_DISP8: begin
        disp_c = {{8{disp_lo[7]}}, disp_lo};
        disp_len_c = 2'd1;
      end
      `MOD_MODE_DISP16: begin
        disp_c = {disp_hi, disp_lo};
        disp_len_c = 2'd2;
      end
      default: begin
        disp_c = 16'h0000;
        disp_len_c = 2'd0;
      end
    endcase
  end
  // base and index per rm code
  reg [15:0] base_c;
  reg [15:0] index_c;
  reg uses_frame_c;
  always @* begin
    base_c = 16'h0000;
    index_c = 16'h0000;
    uses_frame_c = 1'b0;
    case (rm_f)
      3'h0: begin
        base_c = base_word_reg;
        index_c = source_index_reg;
      end
      3'h1: begin
        base_c = base_word_reg;
        index_c = dest_index_reg;
      end
      3'h2: begin
        base_c = frame_base_reg;
        index_c = source_index_reg;
        uses_frame_c = 1'b1;
      end
      3'h3: begin
        base_c = frame_base_reg;
        index_c = dest_index_reg;
        uses_frame_c = 1'b1;
      end
      3'h4: base_c = source_index_reg;
      3'h5: base_c = dest_index_reg;
      3'h6: begin
        // direct form has no base register at all
        base_c = is_direct ? 16'h0000 : frame_base_reg;
        uses_frame_c = ~is_direct;
      end
      default: base_c = base_word_reg;
    endcase
  end
  // carries past bit 15 are dropped
  wire [17:0] sum_wide = {2'h0, base_c} + {2'h0, index_c} + {2'h0, disp_c};
  wire [15:0] eff_addr_c = sum_wide[15:0];
  wire mem_c = (mode_f != `MOD_MODE_REG);
  // segment choice
  reg [1:0] seg_sel_c;
  always @* begin
    if (str_dst) begin
      seg_sel_c = `MOD_SEG_EXTRA;
    end else if (ovr_en) begin
      seg_sel_c = ovr_f;
    end else if (uses_frame_c) begin
      seg_sel_c = `MOD_SEG_STACK;
    end else begin
      seg_sel_c = `MOD_SEG_DATA;
    end
  end
  reg [15:0] seg_val_c;
  always @* begin
    case (seg_sel_c)
      `MOD_SEG_EXTRA: seg_val_c = extra_segment;
      `MOD_SEG_CODE: seg_val_c = code_segment;
      `MOD_SEG_STACK: seg_val_c = stack_segment;
      default: seg_val_c = data_segment;
    endcase
  end
  wire [19:0] phys_c = {seg_val_c, 4'h0} + {4'h0, eff_addr_c};
  wire [7:0] xfer_c = (mem_c && word_f && wide_f) ? `MOD_WORD_XFER_CYCLES : 8'h00;
  wire [7:0] cost_c = (mem_c ? `MOD_ADDR_CYCLES : 8'h00) + xfer_c;

  // ----------------------------------------
  // axi write path
  // ----------------------------------------
  reg aw_hold_reg;
  reg [7:0] aw_addr_reg;
  reg w_hold_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_reg & ~s_axi_bvalid;
  wire wr_fire = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  // held address is word aligned, so the byte compare is exact
  wire wr_map = (aw_addr_reg <= `MOD_OFF_SEG_SD) && (aw_addr_reg != 8'h0C);
  wire start_c = wr_fire && (aw_addr_reg == `MOD_OFF_CMD) && w_strb_reg[0]
    && w_data_reg[`MOD_CMD_START];
  // inputs are frozen while a calculation runs
  wire wr_ok = wr_fire & state_reg[0];
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MOD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `MOD_RESP_OKAY : `MOD_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= `MOD_CTRL_RST;
      stream_reg <= 32'h0000_0000;
      gpr_ac_reg <= 32'h0000_0000;
      gpr_db_reg <= 32'h0000_0000;
      gpr_sf_reg <= 32'h0000_0000;
      gpr_sd_reg <= 32'h0000_0000;
      seg_ec_reg <= 32'h0000_0000;
      seg_sd_reg <= 32'h0000_0000;
    end else if (wr_ok) begin
      case (aw_addr_reg)
        `MOD_OFF_CTRL: ctrl_reg <= merge_strb(ctrl_reg, w_data_reg, w_strb_reg);
        `MOD_OFF_STREAM: stream_reg <= merge_strb(stream_reg, w_data_reg, w_strb_reg);
        `MOD_OFF_GPR_AC: gpr_ac_reg <= merge_strb(gpr_ac_reg, w_data_reg, w_strb_reg);
        `MOD_OFF_GPR_DB: gpr_db_reg <= merge_strb(gpr_db_reg, w_data_reg, w_strb_reg);
        `MOD_OFF_GPR_SF: gpr_sf_reg <= merge_strb(gpr_sf_reg, w_data_reg, w_strb_reg);
        `MOD_OFF_GPR_SD: gpr_sd_reg <= merge_strb(gpr_sd_reg, w_data_reg, w_strb_reg);
        `MOD_OFF_SEG_EC: seg_ec_reg <= merge_strb(seg_ec_reg, w_data_reg, w_strb_reg);
        `MOD_OFF_SEG_SD: seg_sd_reg <= merge_strb(seg_sd_reg, w_data_reg, w_strb_reg);
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // ----------------------------------------
  // calculation sequencer
  // ----------------------------------------
  reg [2:0] state_next;
  always @* begin
    case (state_reg)
      ST_IDLE: state_next = start_c ? ST_CALC : ST_IDLE;
      ST_CALC: state_next = (cnt_reg <= 8'h01) ? ST_FINISH : ST_CALC;
      ST_FINISH: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      done_reg <= 1'b0;
      eff_addr_reg <= 16'h0000;
      phys_reg <= 20'h00000;
      oper_reg <= 16'h0000;
      regfld_reg <= 16'h0000;
      mem_reg <= 1'b0;
      seg_sel_reg <= 2'h0;
      disp_len_reg <= 2'h0;
      cost_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      case (state_reg)
        ST_IDLE: begin
          if (start_c) begin
            done_reg <= 1'b0;
            // register-direct form skips the address stage
            cnt_reg <= mem_c ? `MOD_ADDR_CYCLES : 8'h01;
          end
        end
        ST_CALC: cnt_reg <= cnt_reg - 8'h01;
        ST_FINISH: begin
          done_reg <= 1'b1;
          mem_reg <= mem_c;
          eff_addr_reg <= mem_c ? eff_addr_c : 16'h0000;
          phys_reg <= mem_c ? phys_c : 20'h00000;
          oper_reg <= mem_c ? 16'h0000 : reg_pick(rm_f, word_f, reg_bank);
          regfld_reg <= reg_pick(reg_f, word_f, reg_bank);
          seg_sel_reg <= seg_sel_c;
          disp_len_reg <= disp_len_c;
          cost_reg <= cost_c;
        end
        default: cnt_reg <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // axi read path
  // ----------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  reg [31:0] rd_c;
  reg rd_err_c;
  always @* begin
    rd_err_c = 1'b0;
    case ({s_axi_araddr[7:2], 2'b00})
      `MOD_OFF_CTRL: rd_c = ctrl_reg;
      `MOD_OFF_CMD: rd_c = {31'h0, ~state_reg[0]};
      `MOD_OFF_STREAM: rd_c = stream_reg;
      `MOD_OFF_GPR_AC: rd_c = gpr_ac_reg;
      `MOD_OFF_GPR_DB: rd_c = gpr_db_reg;
      `MOD_OFF_GPR_SF: rd_c = gpr_sf_reg;
      `MOD_OFF_GPR_SD: rd_c = gpr_sd_reg;
      `MOD_OFF_SEG_EC: rd_c = seg_ec_reg;
      `MOD_OFF_SEG_SD: rd_c = seg_sd_reg;
      `MOD_OFF_EFF_ADDR: rd_c = {16'h0000, eff_addr_reg};
      `MOD_OFF_PHYS: rd_c = {12'h000, phys_reg};
      `MOD_OFF_OPER: rd_c = {regfld_reg, oper_reg};
      `MOD_OFF_STATUS: begin
        rd_c = {16'h0000, cost_reg, 1'b0, seg_sel_reg, disp_len_reg, mem_reg,
          done_reg, ~state_reg[0]};
      end
      default: begin
        rd_c = 32'h0000_0000;
        rd_err_c = 1'b1;
      end
    endcase
  end
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MOD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_c;
      s_axi_rresp <= rd_err_c ? `MOD_RESP_SLVERR : `MOD_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: dv/mod_decode_sva.sv
`timescale 1ns/1ps
module mod_decode_sva (
  input wire mclk,
  input wire nrst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  // ---
  // shadow of control word
  // ---
  reg [7:0] ra_reg;
  reg [13:0] ct_reg;
  wire wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ra_reg <= 8'h00;
      ct_reg <= 14'h0000;
    end else begin
      if (s_axi_arvalid && s_axi_arready)
        ra_reg <= s_axi_araddr;
      if (wt && s_axi_awaddr == 8'h00)
        ct_reg <= s_axi_wdata[13:0];
    end
  end
  wire [2:0] rm = ct_reg[2:0];
  wire [1:0] md = ct_reg[7:6];
  wire dir = md == 2'h0 && rm == 3'h6;
  wire mem = md != 2'h3;
  // only completed status reads are judged
  wire st = ra_reg == 8'h34 && s_axi_rvalid && s_axi_rdata[1];
  wire [1:0] dn = (dir || md == 2'h2) ? 2'h2 : {1'h0, md == 2'h1};
  wire fr = (rm == 3'h2 || rm == 3'h3 || rm == 3'h6) && !dir;
  wire [1:0] sg = ct_reg[12] ? 2'h0 : ct_reg[11] ? ct_reg[10:9] : fr ? 2'h2 : 2'h3;
  wire [7:0] cost = (ct_reg[8] && ct_reg[13]) ? 8'h08 : 8'h04;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_RD_ANSWER:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_RD_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_WR_ANSWER:
    assert property (wt |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  AST_WR_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_REG_MODE:
    assert property (st && !mem |-> !s_axi_rdata[2] && s_axi_rdata[15:8] == 8'h00)
    else $error("register mode formed memory operand");
  AST_DISP_COUNT:
    assert property (st && mem |-> s_axi_rdata[4:3] == dn)
    else $error("displacement byte count wrong");
  AST_SEGMENT:
    assert property (st && mem |-> s_axi_rdata[6:5] == sg)
    else $error("segment choice wrong");
  AST_COST:
    assert property (st && mem |-> s_axi_rdata[2] && s_axi_rdata[15:8] == cost)
    else $error("address cost wrong");
  AST_NOT_BUSY:
    assert property (st |-> !s_axi_rdata[0])
    else $error("busy with done");
endmodule

bind mod_decode mod_decode_sva i_mod_decode_sva (.*);

// File: dv/mod_host.sv
`timescale 1ns/1ps
module mod_host (
  input wire mclk,
  output reg [7:0] s_axi_awaddr,
  output reg s_axi_awvalid,
  input wire s_axi_awready,
  output reg [31:0] s_axi_wdata,
  output reg [3:0] s_axi_wstrb,
  output reg s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output reg s_axi_bready,
  output reg [7:0] s_axi_araddr,
  output reg s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output reg s_axi_rready
);
  // extra cycles before accepting an answer
  integer slow;
  initial begin
    slow = 0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'h0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
  end
  // released payloads are inverted, never left showing old values
  task wr(input [7:0] a, input [31:0] v, output [1:0] rsp);
    reg ta, tw;
    begin
      ta = 1'h0;
      tw = 1'h0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      while (!(ta && tw)) begin
        @(negedge mclk);
        ta = ta | (s_axi_awvalid & s_axi_awready);
        tw = tw | (s_axi_wvalid & s_axi_wready);
        @(posedge mclk);
        if (ta) begin
          s_axi_awvalid <= 1'h0;
          s_axi_awaddr <= ~a;
        end
        if (tw) begin
          s_axi_wvalid <= 1'h0;
          s_axi_wdata <= ~v;
        end
      end
      do @(negedge mclk); while (!s_axi_bvalid);
      repeat (slow) @(posedge mclk);
      @(posedge mclk);
      s_axi_bready <= 1'h1;
      // response taken as it stands at the accepting edge
      @(negedge mclk);
      rsp = s_axi_bresp;
      @(posedge mclk);
      s_axi_bready <= 1'h0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] v, output [1:0] rsp);
    begin
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(negedge mclk); while (!s_axi_arready);
      @(posedge mclk);
      s_axi_arvalid <= 1'h0;
      s_axi_araddr <= ~a;
      do @(negedge mclk); while (!s_axi_rvalid);
      repeat (slow) @(posedge mclk);
      @(posedge mclk);
      s_axi_rready <= 1'h1;
      @(negedge mclk);
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge mclk);
      s_axi_rready <= 1'h0;
    end
  endtask
endmodule

// File: dv/mod_decode_tb.sv
`timescale 1ns/1ps
module mod_decode_tb;
  reg mclk = 1'h0;
  reg nrst = 1'h0;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  wire s_axi_rvalid, s_axi_rready;
  integer err_total = 0;
  integer total_checks = 0;
  integer i, m, k, n;
  reg [15:0] r [0:7];
  reg [15:0] sgv [0:3];
  reg [15:0] sv;
  reg [31:0] d;
  reg [1:0] rs;
  always #4 mclk = ~mclk;
  mod_decode i_mod_decode (.*);
  mod_host i_mod_host (.*);
  // ---
  // helpers
  // ---
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    i_mod_host.wr(a, v, rs);
  endtask
  task rd(input [7:0] a);
    i_mod_host.rd(a, d, rs);
  endtask
  function [15:0] eff_of(input [1:0] md, input [2:0] rm, input [15:0] s);
    reg [15:0] b;
    reg [15:0] dp;
    begin
      case (rm)
        3'h0: b = r[3] + r[6];
        3'h1: b = r[3] + r[7];
        3'h2: b = r[5] + r[6];
        3'h3: b = r[5] + r[7];
        3'h4: b = r[6];
        3'h5: b = r[7];
        3'h6: b = r[5];
        default: b = r[3];
      endcase
      dp = md == 2'h1 ? {{8{s[7]}}, s[7:0]} : md == 2'h2 ? s : 16'h0000;
      eff_of = (md == 2'h0 && rm == 3'h6) ? s : b + dp;
    end
  endfunction
  function [15:0] reg_of(input w, input [2:0] c);
    reg_of = w ? r[c] : c[2] ? {8'h00, r[c[1:0]][15:8]} : {8'h00, r[c[1:0]][7:0]};
  endfunction
  function [19:0] phys(input [1:0] s, input [15:0] e);
    phys = {sgv[s], 4'h0} + {4'h0, e};
  endfunction
  task run(input [13:0] c);
    begin
      wr(8'h00, {18'h00000, c});
      wr(8'h04, 32'h0000_0001);
      rd(8'h04);
      if (c[7:6] != 2'h3 && i_mod_host.slow == 0)
        chk(d[0], 1'h1);
      n = 0;
      rd(8'h34);
      // an unhurried host sees the result on its first status poll
      if (i_mod_host.slow == 0)
        chk(d[1], 1'h1);
      while (!d[1] && n < 40) begin
        rd(8'h34);
        n = n + 1;
      end
      chk(d[1:0], 2'h2);
    end
  endtask
  // ---
  // scenarios
  // ---
  task t_bus;
    begin
      rd(8'h00);
      chk(d, 32'h0000_0000);
      rd(8'h34);
      chk(d, 32'h0000_0000);
      rd(8'h0C);
      chk(rs, 2'h2);
      wr(8'h28, 32'h0000_0001);
      chk(rs, 2'h2);
      for (i = 0; i < 4; i = i + 1)
        wr(8'h10 + 8'(4 * i), {r[2 * i + 1], r[2 * i]});
      wr(8'h20, {sgv[1], sgv[0]});
      wr(8'h24, {sgv[3], sgv[2]});
      rd(8'h14);
      chk(d, {r[3], r[2]});
    end
  endtask
  task t_mem(input [15:0] s);
    begin
      sv = s;
      wr(8'h08, {16'h0000, s});
      for (m = 0; m < 3; m = m + 1)
        for (k = 0; k < 8; k = k + 1) begin
          run({6'h00, m[1:0], 3'h2, k[2:0]});
          rd(8'h28);
          chk(d[15:0], eff_of(m[1:0], k[2:0], s));
          rd(8'h2C);
          i = (k == 2 || k == 3 || (k == 6 && m != 0)) ? 2 : 3;
          chk(d[19:0], phys(i[1:0], eff_of(m[1:0], k[2:0], s)));
        end
    end
  endtask
  task t_reg;
    for (m = 0; m < 2; m = m + 1)
      for (k = 0; k < 8; k = k + 1) begin
        run({5'h00, m[0], 2'h3, k[2:0] ^ 3'h5, k[2:0]});
        rd(8'h30);
        chk(d, {reg_of(m[0], k[2:0] ^ 3'h5), reg_of(m[0], k[2:0])});
        rd(8'h28);
        chk(d, 32'h0000_0000);
      end
  endtask
  task t_seg;
    begin
      i_mod_host.slow = 2;
      for (m = 0; m < 4; m = m + 1) begin
        run({3'h1, m[1:0], 1'h0, 8'h03});
        rd(8'h2C);
        chk(d[19:0], phys(m[1:0], r[5] + r[7]));
      end
      run({3'h3, 2'h2, 1'h0, 8'h45});
      rd(8'h2C);
      chk(d[19:0], phys(2'h0, eff_of(2'h1, 3'h5, sv)));
      i_mod_host.slow = 0;
      run({3'h4, 2'h0, 1'h1, 8'h87});
      chk(d[15:8], 8'h08);
      run({3'h0, 2'h0, 1'h1, 8'h87});
      chk(d[15:8], 8'h04);
    end
  endtask
  initial begin
    r[0] = 16'h1234;
    r[1] = 16'hA5C3;
    r[2] = 16'h0F0F;
    r[3] = 16'hFF00;
    r[4] = 16'h8000;
    r[5] = 16'h9001;
    r[6] = 16'h7F80;
    r[7] = 16'h80C0;
    sgv[0] = 16'h1000;
    sgv[1] = 16'h2000;
    sgv[2] = 16'h3000;
    sgv[3] = 16'h4000;
    repeat (12) @(posedge mclk);
    nrst <= 1'h1;
    t_bus;
    t_mem(16'hC381);
    t_mem(16'h047F);
    t_reg;
    t_seg;
    end_of_test;
  end
  initial begin
    #400000;
    err_total = err_total + 1;
    end_of_test;
  end
endmodule
